// >>> rtl/adc_conversion_sequencer.sv
// Digital control of a successive-approximation converter: APB registers, prescaler,
// sample/resolve timing, approximation register, channel stepping and result storage
// Assumes an APB master on i_clk and an analog front end whose comparator is asynchronous
`include "adc_seq_params.svh"

// Behaviour
// R01: Initial sample plus transfer take four converter clocks before final sampling.
// R02: Final sample field gives 2, 4, 8 or 16 converter clocks.
// R03: Ten-bit select picks 10-bit conversion, else 8-bit.
// R04: Results are placed right-aligned in result registers automatically.
// R05: Any write to the command register starts a new sequence.
// R06: Control write aborts running sequence and clears all completion flags.
// R07: Mode number is continuous, multi-channel, eight-conversion bits concatenated.
// R08: Four-bit channel field selects one of 16 inputs or block start.
// R09: Four conversions per sequence, or eight when eight-conversion bit set.
// R10: Continuous bit clear runs one sequence; set repeats forever.
// R11: Single-channel modes reuse one channel; multi-channel converts a channel block.
// R12: Single-channel results go to result registers 0 upward in order.
// R13: Multi-channel converts consecutive channels from the selected one, one result each.
// R14: Each result register's completion flag sets when it receives a result.
// R15: Single-sequence modes set sequence complete after the last conversion.
// R16: Continuous modes set sequence complete after the first sequence, keep converting.
// R17: Continuous modes overwrite result registers on each repeat.
// R18: Setup write halts until a command write restarts with new parameters.
// R19: Resolution lasts ten converter clocks for 8-bit, twelve for 10-bit.
// R20: Resolution sets MSB, clears rest, then keeps or clears bits descending.
// R21: Converter clock is 5-bit modulus divide then divide by two; zero reserved.
// R22: Each repeated sequence restarts at result index and channel offset zero.
// R23: Completion flags stay set until a control register write clears them.
module adc_conversion_sequencer (
    input  wire logic                      i_clk,        // System clock, 50 MHz
    input  wire logic                      i_rst_n,      // Asynchronous reset, active low
    input  wire logic                      i_psel,       // APB select
    input  wire logic                      i_penable,    // APB access phase
    input  wire logic                      i_pwrite,     // APB write
    input  wire logic [11:0]               i_paddr,      // APB byte address
    input  wire logic [31:0]               i_pwdata,     // APB write data
    output logic      [31:0]               o_prdata,     // APB read data
    output logic                           o_pready,     // APB ready
    output logic                           o_pslverr,    // APB error on unmapped address
    input  wire logic                      i_comparator, // Comparator: 1 keeps the trial bit
    output adc_seq_pkg::fe_ctrl_type       o_front_end,  // Phase, channel and DAC code
    output logic                           o_conv_done   // Pulse when a result is stored
);

    // Register state
    logic [4:0]                 div_reg;
    logic [1:0]                 fss_reg;
    logic                       ten_bit_reg;
    logic [3:0]                 chan_sel_reg;
    logic                       eight_reg;
    logic                       multi_reg;
    logic                       cont_reg;
    logic [7:0]                 flags_reg;
    logic                       seq_done_reg;
    logic [9:0]                 result_reg [8];
    logic                       pready_reg;
    logic                       pslverr_reg;
    logic [31:0]                prdata_reg;

    // Sequencer state
    adc_seq_pkg::seq_state_type state_reg;
    adc_seq_pkg::seq_state_type state_next;
    logic [4:0]                 tcnt_reg;
    logic [2:0]                 idx_reg;
    logic [9:0]                 sar_reg;
    logic [4:0]                 pre_cnt_reg;
    logic                       half_reg;
    logic                       comp_meta_reg;
    logic                       comp_sync_reg;
    logic                       conv_done_reg;
    adc_seq_pkg::fe_ctrl_type   fe_reg;

    // Decoded strobes and helpers
    logic                       apb_commit;
    logic                       wr_setup;
    logic                       wr_command;
    logic                       addr_mapped;
    logic                       conv_tick;
    logic [4:0]                 div_eff;
    logic [4:0]                 final_len;
    logic [4:0]                 res_len;
    logic [4:0]                 res_bits;
    logic [2:0]                 last_idx;
    logic [2:0]                 mode;
    logic                       store_now;
    logic [3:0]                 channel_now;
    logic [3:0]                 bit_pos;
    logic [31:0]                read_mux;

    // APB commit happens only at the edge where the master sees ready high
    assign apb_commit  = i_psel & i_penable & pready_reg;
    assign addr_mapped = (i_paddr == `ADDR_SETUP) || (i_paddr == `ADDR_COMMAND) ||
                         (i_paddr == `ADDR_STATUS) ||
                         ((i_paddr >= `ADDR_RESULT_BASE) && (i_paddr <= `ADDR_RESULT_LAST) &&
                          (i_paddr[1:0] == 2'h0));
    assign wr_setup    = apb_commit & i_pwrite & (i_paddr == `ADDR_SETUP);
    assign wr_command  = apb_commit & i_pwrite & (i_paddr == `ADDR_COMMAND);

    // Mode number and sequence geometry
    assign mode        = {cont_reg, multi_reg, eight_reg};                  // R07
    assign last_idx    = mode[0] ? 3'h7 : 3'h3;                             // R09
    assign final_len   = 5'(5'h02 << fss_reg);                              // R02
    assign res_len     = ten_bit_reg ? `TEN_BIT_SELECT_CYCLES : `RES8_CYCLES;        // R19
    assign res_bits    = ten_bit_reg ? `TEN_BIT_SELECT_BITS : `RES8_BITS;            // R03
    assign channel_now = mode[1] ? 4'(chan_sel_reg + {1'b0, idx_reg})       // R13
                                 : chan_sel_reg;                            // R11
    assign store_now   = conv_tick && (state_reg == adc_seq_pkg::ST_RESOLVE) &&
                         (tcnt_reg == 5'(res_len - 5'h01));
    assign bit_pos     = 4'(res_bits - tcnt_reg);

    // Prescaler: modulus stage divides by div+1 (by 2 when div is zero), second stage halves it
    assign div_eff   = (div_reg == 5'h00) ? 5'h01 : div_reg;                // R21
    assign conv_tick = (pre_cnt_reg == div_eff) & half_reg;                 // R21

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pre_cnt_reg <= 5'h00;
            half_reg    <= 1'b0;
        end else if (pre_cnt_reg >= div_eff) begin
            pre_cnt_reg <= 5'h00;
            half_reg    <= ~half_reg;                                      // R21
        end else begin
            pre_cnt_reg <= 5'(pre_cnt_reg + 5'h01);
        end
    end

    // Comparator crosses in through two flip-flops
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            comp_meta_reg <= 1'b0;
            comp_sync_reg <= 1'b0;
        end else begin
            comp_meta_reg <= i_comparator;
            comp_sync_reg <= comp_meta_reg;
        end
    end

    // APB handshake: one wait state, read data and error captured on the same edge as ready
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
        end else if (i_psel && i_penable && !pready_reg) begin
            pready_reg  <= 1'b1;
            pslverr_reg <= ~addr_mapped;
            prdata_reg  <= i_pwrite ? 32'h0000_0000 : read_mux;
        end else begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end
    end

    // Read decode; unused bits read as zero
    always_comb begin
        read_mux = 32'h0000_0000;
        if (i_paddr == `ADDR_SETUP) begin
            read_mux[`SETUP_DIV_MSB:`SETUP_DIV_LSB] = div_reg;
            read_mux[`SETUP_FSS_MSB:`SETUP_FSS_LSB] = fss_reg;
            read_mux[`SETUP_TEN_BIT]                = ten_bit_reg;
        end else if (i_paddr == `ADDR_COMMAND) begin
            read_mux[`CMD_CHAN_MSB:`CMD_CHAN_LSB] = chan_sel_reg;
            read_mux[`CMD_EIGHT]                  = eight_reg;
            read_mux[`CMD_MULTI]                  = multi_reg;
            read_mux[`CMD_CONT]                   = cont_reg;
        end else if (i_paddr == `ADDR_STATUS) begin
            read_mux[`STAT_FLAGS_MSB:`STAT_FLAGS_LSB] = flags_reg;
            read_mux[`STAT_SEQ_DONE]                  = seq_done_reg;
            read_mux[`STAT_BUSY]                      = (state_reg != adc_seq_pkg::ST_IDLE);
            read_mux[`STAT_IDX_MSB:`STAT_IDX_LSB]     = idx_reg;
        end else if (addr_mapped) begin
            read_mux[9:0] = result_reg[i_paddr[4:2]];
        end
    end

    // Setup register: divider, final sample length, resolution
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            div_reg     <= `SETUP_DIV_RESET;
            fss_reg     <= `SETUP_FSS_RESET;
            ten_bit_reg <= 1'b0;
        end else if (wr_setup && !pslverr_reg) begin
            div_reg     <= i_pwdata[`SETUP_DIV_MSB:`SETUP_DIV_LSB];
            fss_reg     <= i_pwdata[`SETUP_FSS_MSB:`SETUP_FSS_LSB];
            ten_bit_reg <= i_pwdata[`SETUP_TEN_BIT];
        end
    end

    // Command register: channel and mode bits
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            chan_sel_reg <= 4'h0;
            eight_reg    <= 1'b0;
            multi_reg    <= 1'b0;
            cont_reg     <= 1'b0;
        end else if (wr_command) begin
            chan_sel_reg <= i_pwdata[`CMD_CHAN_MSB:`CMD_CHAN_LSB];         // R08
            eight_reg    <= i_pwdata[`CMD_EIGHT];
            multi_reg    <= i_pwdata[`CMD_MULTI];
            cont_reg     <= i_pwdata[`CMD_CONT];
        end
    end

    // Sequencer next state; a control write overrides any tick
    always_comb begin
        state_next = state_reg;
        if (wr_command) begin
            state_next = adc_seq_pkg::ST_INIT;                              // R05
        end else if (wr_setup) begin
            state_next = adc_seq_pkg::ST_IDLE;                              // R18
        end else if (conv_tick) begin
            unique case (state_reg)
                adc_seq_pkg::ST_IDLE: begin
                    state_next = adc_seq_pkg::ST_IDLE;
                end
                adc_seq_pkg::ST_INIT: begin
                    if (tcnt_reg == 5'(`INIT_CYCLES - 5'h01)) begin
                        state_next = adc_seq_pkg::ST_XFER;
                    end
                end
                adc_seq_pkg::ST_XFER: begin
                    if (tcnt_reg == 5'(`INIT_XFER_CYCLES - 5'h01)) begin    // R01
                        state_next = adc_seq_pkg::ST_FINAL;
                    end
                end
                adc_seq_pkg::ST_FINAL: begin
                    if (tcnt_reg == 5'(final_len - 5'h01)) begin            // R02
                        state_next = adc_seq_pkg::ST_RESOLVE;
                    end
                end
                adc_seq_pkg::ST_RESOLVE: begin
                    if (store_now) begin
                        state_next = ((idx_reg == last_idx) && !cont_reg)   // R10
                                     ? adc_seq_pkg::ST_IDLE : adc_seq_pkg::ST_INIT;
                    end
                end
                default: begin
                    state_next = adc_seq_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // State register and portion counter
    // Transfer counts on from the initial portion so four cycles precede final sampling
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= adc_seq_pkg::ST_IDLE;
            tcnt_reg  <= 5'h00;
        end else begin
            state_reg <= state_next;
            if (wr_command || wr_setup) begin
                tcnt_reg <= 5'h00;                                          // R06
            end else if (conv_tick) begin
                if (state_next != state_reg || store_now) begin
                    tcnt_reg <= (state_next == adc_seq_pkg::ST_XFER) ? `INIT_CYCLES : 5'h00;
                end else begin
                    tcnt_reg <= 5'(tcnt_reg + 5'h01);
                end
            end
        end
    end

    // Result index: restart at zero on a command and on each repeat
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            idx_reg <= 3'h0;
        end else if (wr_command) begin
            idx_reg <= 3'h0;
        end else if (store_now) begin
            idx_reg <= (idx_reg == last_idx) ? 3'h0 : 3'(idx_reg + 3'h1);   // R22
        end
    end

    // Approximation register: MSB trial first, then one bit per converter clock
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sar_reg <= 10'h000;
        end else if (conv_tick && state_reg == adc_seq_pkg::ST_FINAL &&
                     state_next == adc_seq_pkg::ST_RESOLVE) begin
            sar_reg <= ten_bit_reg ? 10'h200 : 10'h080;                     // R20
        end else if (conv_tick && state_reg == adc_seq_pkg::ST_RESOLVE &&
                     tcnt_reg < res_bits) begin
            if (!comp_sync_reg) begin
                sar_reg[bit_pos - 4'h1] <= 1'b0;                            // R20
            end
            if (bit_pos > 4'h1) begin
                sar_reg[bit_pos - 4'h2] <= 1'b1;                            // R20
            end
        end
    end

    // Result storage, low-aligned for either resolution
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int i = 0; i < 8; i++) begin
                result_reg[i] <= 10'h000;
            end
        end else if (store_now && !wr_command && !wr_setup) begin
            result_reg[idx_reg] <= sar_reg;                                 // R04 R12 R17
        end
    end

    // Completion flags: a control write aborts, so a store in the same cycle is dropped
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            flags_reg    <= 8'h00;
            seq_done_reg <= 1'b0;
        end else begin
            flags_reg <= ((wr_command || wr_setup) ? 8'h00 : flags_reg)     // R06 R23
                         | ((store_now && !wr_command && !wr_setup) ? 8'(8'h01 << idx_reg) : 8'h00); // R14
            seq_done_reg <= ((wr_command || wr_setup) ? 1'b0 : seq_done_reg)
                            | (store_now && !wr_command && !wr_setup &&
                               idx_reg == last_idx);                        // R15 R16
        end
    end

    // Front end drive and completion pulse, all registered
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            fe_reg        <= '{phase: adc_seq_pkg::PH_IDLE, channel: 4'h0, dac_code: 10'h000};
            conv_done_reg <= 1'b0;
        end else begin
            fe_reg.channel  <= channel_now;                                 // R11 R13
            fe_reg.dac_code <= sar_reg;
            unique case (state_next)
                adc_seq_pkg::ST_IDLE:    fe_reg.phase <= adc_seq_pkg::PH_IDLE;
                adc_seq_pkg::ST_INIT:    fe_reg.phase <= adc_seq_pkg::PH_INIT;
                adc_seq_pkg::ST_XFER:    fe_reg.phase <= adc_seq_pkg::PH_XFER;
                adc_seq_pkg::ST_FINAL:   fe_reg.phase <= adc_seq_pkg::PH_FINAL;
                adc_seq_pkg::ST_RESOLVE: fe_reg.phase <= adc_seq_pkg::PH_RESOLVE;
                default:                 fe_reg.phase <= adc_seq_pkg::PH_IDLE;
            endcase
            conv_done_reg <= store_now && !wr_command && !wr_setup;
        end
    end

    assign o_prdata    = prdata_reg;
    assign o_pready    = pready_reg;
    assign o_pslverr   = pslverr_reg;
    assign o_front_end = fe_reg;
    assign o_conv_done = conv_done_reg;

endmodule : adc_conversion_sequencer

// >>> rtl/adc_seq_params.svh
// Offsets, field positions, reset values and timing counts for the conversion sequencer
// Assumes inclusion by the package and by the sequencer module
`ifndef ADC_SEQ_PARAMS_SVH
`define ADC_SEQ_PARAMS_SVH

// Register byte addresses
`define ADDR_SETUP          12'h000
`define ADDR_COMMAND        12'h004
`define ADDR_STATUS         12'h008
`define ADDR_RESULT_BASE    12'h020
`define ADDR_RESULT_LAST    12'h03C

// Setup register fields
`define SETUP_DIV_LSB       0
`define SETUP_DIV_MSB       4
`define SETUP_FSS_LSB       5
`define SETUP_FSS_MSB       6
`define SETUP_TEN_BIT       7
`define SETUP_DIV_RESET     5'h03
`define SETUP_FSS_RESET     2'h0

// Command register fields
`define CMD_CHAN_LSB        0
`define CMD_CHAN_MSB        3
`define CMD_EIGHT           4
`define CMD_MULTI           5
`define CMD_CONT            6

// Status register fields
`define STAT_FLAGS_LSB      0
`define STAT_FLAGS_MSB      7
`define STAT_SEQ_DONE       8
`define STAT_BUSY           9
`define STAT_IDX_LSB        10
`define STAT_IDX_MSB        12

// Converter clock cycles per portion and bits resolved per resolution
`define INIT_XFER_CYCLES    5'h04
`define INIT_CYCLES         5'h02
`define RES8_CYCLES         5'h0A
`define TEN_BIT_SELECT_CYCLES        5'h0C
`define RES8_BITS           5'h08
`define TEN_BIT_SELECT_BITS          5'h0A

`endif

// >>> rtl/adc_seq_pkg.sv
// Types shared by the conversion sequencer and its bench
// Assumes the constants header sits beside it
`include "adc_seq_params.svh"

package adc_seq_pkg;

    // Sequencer states, Gray coded along the conversion path
    typedef enum logic [2:0] {
        ST_IDLE    = 3'h0,
        ST_INIT    = 3'h1,
        ST_XFER    = 3'h3,
        ST_FINAL   = 3'h2,
        ST_RESOLVE = 3'h6
    } seq_state_type;

    // Analog front end phase
    typedef enum logic [2:0] {
        PH_IDLE    = 3'h0,
        PH_INIT    = 3'h1,
        PH_XFER    = 3'h2,
        PH_FINAL   = 3'h3,
        PH_RESOLVE = 3'h4
    } fe_phase_type;

    // Controls sent to multiplexer and DAC array
    typedef struct packed {
        fe_phase_type phase;
        logic [3:0]   channel;
        logic [9:0]   dac_code;
    } fe_ctrl_type;

endpackage : adc_seq_pkg

// >>> verif/adc_conversion_sequencer_bench.sv
// Self-checking bench for the conversion sequencer over APB
// Assumes the analog model beside the design and a 50 MHz clock
`include "adc_seq_params.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_errors++; $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module adc_conversion_sequencer_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_clk = 1'b0, i_rst_n = 1'b0, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
    logic [11:0] i_paddr = 12'h000;
    logic [31:0] i_pwdata = 32'h0, o_prdata, rd;
    logic        o_pready, o_pslverr, o_conv_done, cmp, err, ten = 1'b0;
    adc_seq_pkg::fe_ctrl_type fe_ctrl;
    int          n_errors = 0, checked = 0, gap = 0, cnt = 0, dones = 0;
    // Rows: setup byte, command byte, expected completion flags
    logic [23:0] rows [8] = '{24'h01030F, 24'h2117FF, 24'hC12E0F, 24'hE139FF,
                              24'h81450F, 24'h0150FF, 24'hA16C0F, 24'h417DFF};
    adc_conversion_sequencer dut (.i_clk, .i_rst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
        .o_prdata, .o_pready, .o_pslverr, .i_comparator(cmp), .o_front_end(fe_ctrl), .o_conv_done);
    adc_front_end_model fe (.i_clk, .i_front_end(fe_ctrl), .i_ten_bit(ten), .o_comparator(cmp));
    // Clock
    initial forever #10 i_clk = ~i_clk;
    // Spacing between stored results
    always @(posedge i_clk) begin
        cnt <= o_conv_done ? 1 : cnt + 1;
        if (o_conv_done) begin
            gap <= cnt;
            dones <= dones + 1;
        end
    end
    // One APB transfer; read data and error land in rd and err
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_clk);
        i_psel <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1'b1;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_pready !== 1'b1 && n < 20);
        rd = o_prdata;
        err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        if (n >= 20) n_errors++;
    endtask : apb
    // Poll status until the sequence flag shows
    task automatic wait_done();
        for (int n = 0; n < 3000; n++) begin
            apb(1'b0, `ADDR_STATUS, 32'h0);
            if (rd[`STAT_SEQ_DONE] === 1'b1) break;
        end
    endtask : wait_done
    // Verdict and end of run
    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : end_sim
    // Watchdog
    initial begin
        #(20 * 60000);
        n_errors++;
        end_sim();
    end
    // Main sequence
    initial begin
        logic [7:0] s, c;
        logic [9:0] v;
        int         k;
        repeat (4) @(posedge i_clk);
        i_rst_n <= 1'b1;
        apb(1'b0, `ADDR_SETUP, 32'h0);
        `CHK(rd, 32'h0000_0003)
        apb(1'b0, 12'h010, 32'h0);
        `CHK({err, rd}, 33'h1_0000_0000)
        apb(1'b1, `ADDR_STATUS, 32'hFFFF_FFFF);
        apb(1'b0, `ADDR_STATUS, 32'h0);
        `CHK(rd[9:0], 10'h000)
        // Every mode, every final sample length, both resolutions
        for (k = 0; k < 8; k++) begin
            {s, c} = rows[k][23:8];
            ten = s[7];
            apb(1'b1, `ADDR_SETUP, {24'h0, s});
            apb(1'b1, `ADDR_COMMAND, {24'h0, c});
            wait_done();
            repeat (100) @(posedge i_clk);
            apb(1'b0, `ADDR_STATUS, 32'h0);
            `CHK(rd[9:0], {c[6], 1'b1, rows[k][7:0]})
            for (int i = 0; i < (c[4] ? 8 : 4); i++) begin
                apb(1'b0, `ADDR_RESULT_BASE + 12'(4 * i), 32'h0);
                v = fe.level(c[5] ? c[3:0] + 4'(i) : c[3:0]) >> (s[7] ? 0 : 2);
                `CHK(rd, {22'h0, v})
            end
            `CHK(gap, 4 * (4 + (2 << s[6:5]) + (s[7] ? 12 : 10)))
        end
        // Restart a running continuous sequence, then halt it
        apb(1'b1, `ADDR_COMMAND, 32'h0000_007D);
        apb(1'b0, `ADDR_STATUS, 32'h0);
        `CHK(rd[8:0], 9'h000)
        wait_done();
        apb(1'b1, `ADDR_SETUP, 32'h0000_0041);
        apb(1'b0, `ADDR_STATUS, 32'h0);
        `CHK(rd[9:0], 10'h000)
        k = dones;
        repeat (300) @(posedge i_clk);
        `CHK(dones, k)
        end_sim();
    end
endmodule : adc_conversion_sequencer_bench

// >>> verif/adc_front_end_model.sv
// Behavioural analog front end: fixed level per channel, ideal comparator
// Assumes the sequencer's front-end controls and the bench's resolution choice
module adc_front_end_model (
    input  wire logic                     i_clk,        // Clock
    input  wire adc_seq_pkg::fe_ctrl_type i_front_end,  // Controls
    input  wire logic                     i_ten_bit,    // Resolution in use
    output logic                          o_comparator  // 1 keeps trial bit
);
    logic [9:0] held = 10'h000;
    logic       idle_bit = 1'b0;
    // Input level of one channel
    function automatic logic [9:0] level(input logic [3:0] ch);
        return {ch, 6'h2D};
    endfunction : level
    // Sample the channel on the final portion; outside resolve the output wanders
    always @(posedge i_clk) begin
        idle_bit <= ~idle_bit;
        if (i_front_end.phase == adc_seq_pkg::PH_FINAL) held <= level(i_front_end.channel) >> (i_ten_bit ? 0 : 2);
    end
    // Compare sampled input against trial code
    assign o_comparator = (i_front_end.phase == adc_seq_pkg::PH_RESOLVE) ? (held >= i_front_end.dac_code)
                                                                           : idle_bit;
endmodule : adc_front_end_model

// >>> verif/adc_seq_assertions.sv
// Port checks for the conversion sequencer
// Assumes binding onto adc_conversion_sequencer and its params header
`include "adc_seq_params.svh"
module adc_seq_assertions (
    input wire logic                     i_clk,        // Clock
    input wire logic                     i_rst_n,      // Reset, active low
    input wire logic                     i_psel,       // Select
    input wire logic                     i_penable,    // Access phase
    input wire logic                     i_pwrite,     // Write
    input wire logic [11:0]              i_paddr,      // Address
    input wire logic [31:0]              i_pwdata,     // Write data
    input wire logic [31:0]              o_prdata,     // Read data
    input wire logic                     o_pready,     // Ready
    input wire logic                     o_pslverr,    // Error
    input wire logic                     i_comparator, // Comparator
    input wire adc_seq_pkg::fe_ctrl_type o_front_end,  // Front end controls
    input wire logic                     o_conv_done   // Stored pulse
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    wire adc_seq_pkg::fe_phase_type ph = o_front_end.phase;
    // Committed writes and phase entries
    sequence s_setup_wr; i_psel && i_penable && o_pready && i_pwrite && i_paddr == `ADDR_SETUP; endsequence
    sequence s_cmd_wr; i_psel && i_penable && o_pready && i_pwrite && i_paddr == `ADDR_COMMAND; endsequence
    sequence s_enter_resolve; $changed(ph) && ph == adc_seq_pkg::PH_RESOLVE; endsequence
    property p_ready_wait; i_psel && $rose(i_penable) |-> !o_pready ##1 o_pready ##1 !o_pready; endproperty
    property p_err_ready; o_pslverr |-> o_pready; endproperty
    property p_done_after_resolve; o_conv_done |-> !$past(o_conv_done) && $past(ph, 2) == adc_seq_pkg::PH_RESOLVE;
    endproperty
    property p_xfer_after_init; $changed(ph) && ph == adc_seq_pkg::PH_XFER |-> $past(ph) == adc_seq_pkg::PH_INIT;
    endproperty
    property p_msb_first;
        s_enter_resolve |-> ($past(ph) == adc_seq_pkg::PH_FINAL) ##1
            (o_front_end.dac_code inside {10'h200, 10'h080});
    endproperty
    property p_chan_hold;
        ph inside {adc_seq_pkg::PH_XFER, adc_seq_pkg::PH_FINAL, adc_seq_pkg::PH_RESOLVE} &&
            $past(ph) != adc_seq_pkg::PH_IDLE |-> $stable(o_front_end.channel);
    endproperty
    property p_setup_halt; s_setup_wr |-> ##[1:2] ph == adc_seq_pkg::PH_IDLE; endproperty
    property p_cmd_start; s_cmd_wr |-> ##[1:70] ph == adc_seq_pkg::PH_INIT; endproperty
    a_ready_wait: assert property (p_ready_wait) else $error("ready not one wait state");
    a_err_ready: assert property (p_err_ready) else $error("error without ready");
    a_done_after_resolve: assert property (p_done_after_resolve) else $error("stray done pulse");
    a_xfer_after_init: assert property (p_xfer_after_init) else $error("transfer not after initial");
    a_msb_first: assert property (p_msb_first) else $error("resolve start code wrong");
    a_chan_hold: assert property (p_chan_hold) else $error("channel moved in conversion");
    a_setup_halt: assert property (p_setup_halt) else $error("setup write did not halt");
    a_cmd_start: assert property (p_cmd_start) else $error("command write did not start");
endmodule : adc_seq_assertions

bind adc_conversion_sequencer adc_seq_assertions chk (.i_clk, .i_rst_n, .i_psel, .i_penable, .i_pwrite,
    .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_comparator, .o_front_end, .o_conv_done);
